// >>> core/hgc_cfg.svh
// Purpose: Constants for the hub global control register bank
// Assumes: Byte-wide registers at byte offsets
// Notes: Included by the design modules and the testbench
`ifndef HGC_CFG_SVH
`define HGC_CFG_SVH
`define HGC_OFS_ADDR 8'h00
`define HGC_OFS_RST 8'h01
`define HGC_OFS_CFG 8'h02
`define HGC_OFS_REV 8'h03
`define HGC_BIT_OVR 0
`define HGC_BIT_RST0 0
`define HGC_BIT_RST1 1
`define HGC_BIT_RELOAD 2
`define HGC_BIT_REFF 0
`define HGC_BIT_PAR 1
`define HGC_BIT_SLEEP 2
`define HGC_BIT_OEN 3
`define HGC_BIT_OMODE 4
`define HGC_BIT_MEN 5
`define HGC_CFG_RESET 8'h1e
// Arbitrary identity values
`define HGC_REV_VAL 4'h9
`define HGC_MASK_VAL 4'h0
`define HGC_CLK_HZ 25000000
`define HGC_REF_MIN_HZ 12000000
`define HGC_REF_MAX_HZ 64000000
`define HGC_REF_DIV 16
`define HGC_WIN_CYC 1000
`define HGC_LOAD_CYC 16
`define HGC_RST_CYC 4
`endif

// >>> core/hgc_pkg.sv
// Purpose: Types for the hub global control register bank
// Assumes: hgc_cfg.svh provides constants
// Notes: Output drive states for the camera-serial transmitters
package hgc_pkg;
	typedef enum logic [2:0] {
		HGC_TX_NORMAL = 3'b001,
		HGC_TX_HIZ = 3'b010,
		HGC_TX_HS0 = 3'b100
	} hgc_tx_e;
	typedef enum logic [2:0] {
		HGC_LD_IDLE = 3'b001,
		HGC_LD_BUSY = 3'b010,
		HGC_LD_DONE = 3'b100
	} hgc_ld_e;
endpackage : hgc_pkg

// >>> core/hgc_refclk_det.sv
// Purpose: Reference clock frequency window check
// Assumes: ref_clk_pin carries the reference divided by HGC_REF_DIV, asynchronous to clk_sys
// Notes: Counts synchronised rising edges over a fixed window
`include "hgc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module hgc_refclk_det #(
	parameter int WIN_CYC = `HGC_WIN_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ref_clk_pin,
	output logic refclk_ok
);
	// Edge limits scaled to the window; a direct reference would alias at clk_sys
	localparam longint DIV_HZ = longint'(`HGC_CLK_HZ) * `HGC_REF_DIV;
	localparam longint MIN_EDGES = longint'(`HGC_REF_MIN_HZ) * WIN_CYC / DIV_HZ;
	localparam longint MAX_EDGES = longint'(`HGC_REF_MAX_HZ) * WIN_CYC / DIV_HZ;
	logic [2:0] sync_q, sync_d;
	logic lvl_q, lvl_d;
	logic [15:0] win_q, win_d;
	logic [15:0] edg_q, edg_d;
	logic ok_q, ok_d;
	always_comb begin
		sync_d = {sync_q[1:0], ref_clk_pin};
		lvl_d = (sync_q[2] == sync_q[1]) ? sync_q[1] : lvl_q;
		win_d = win_q + 16'h0001;
		edg_d = edg_q;
		ok_d = ok_q;
		if (lvl_d && !lvl_q) begin
			edg_d = edg_q + 16'h0001;
		end
		if (win_q == 16'(WIN_CYC - 1)) begin
			win_d = 16'h0000;
			edg_d = 16'h0000;
			ok_d = (edg_q >= 16'(MIN_EDGES)) && (edg_q <= 16'(MAX_EDGES)); // R15
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync_q <= 3'h0;
			lvl_q <= 1'b0;
			win_q <= 16'h0000;
			edg_q <= 16'h0000;
			ok_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			lvl_q <= lvl_d;
			win_q <= win_d;
			edg_q <= edg_d;
			ok_q <= ok_d;
		end
	end
	assign refclk_ok = ok_q;
endmodule : hgc_refclk_det
`default_nettype wire

// >>> core/hgc_global_regs.sv
// Purpose: Shared global control and status registers of a serial-link hub
// Assumes: Decoded byte register port from the bus slave, power_down_pin on sys_rst
// Notes: Soft resets are issued as pulses of a few cycles
// Operation
// R1: Address field bits 7:1 show current address; strap value while override is 0.
// R2: With override bit 0 set, address field is writable and used.
// R3: Writing 1 to reset bit 2 reloads config from ROM; self-clears.
// R4: Init-complete flag sets when ROM configuration load finishes.
// R5: Reset bit 1 resets all logic and registers to defaults; self-clears.
// R6: Reset bit 0 resets logic but keeps registers; self-clears.
// R7: Software should prefer the register-keeping reset.
// R8: Config bit 5 enables the local bus master; resets to 0.
// R9: Config bit 4 at 0 forces unlocked output ports to high impedance.
// R10: Config bit 4 at 1 keeps unlocked ports under per-port control.
// R11: Sleep select 1 with output enable 0 forces outputs high impedance.
// R12: Sleep select 0 with lock low forces outputs to HS-0.
// R13: Config bit 1 enables receive parity checking; resets enabled.
// R14: Config bit 0 forces reference clock present, else detector result.
// R15: Detector reports valid only between 12 MHz and 64 MHz.
// R16: Revision register holds read-only revision 7:4 and mask 3:0.
// R17: Self-clearing bits read 0 once launched; repeated writes retrigger. A reload write while a ROM load is busy is ignored.
`include "hgc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module hgc_global_regs
	import hgc_pkg::*;
#(
	parameter int NUM_TX = 2,
	parameter int LOAD_CYC = `HGC_LOAD_CYC,
	parameter int WIN_CYC = `HGC_WIN_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [6:0] strap_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic ref_clk_pin,
	input wire logic [NUM_TX-1:0] tx_any_lock,
	output logic [6:0] bus_address_field,
	output logic logic_rst,
	output logic cfg_rst,
	output logic rom_load_busy,
	output logic cfg_init_done,
	output logic i2c_master_en,
	output logic parity_check_en,
	output logic refclock_ok_flag,
	output logic [NUM_TX*3-1:0] tx_state
);
	localparam logic [2:0] RST_LEN = 3'(`HGC_RST_CYC);
	logic strap_pend_q, strap_pend_d;
	logic [6:0] strap_q, strap_d;
	logic [6:0] addr_q, addr_d;
	logic ovr_q, ovr_d;
	logic [7:0] cfg_q, cfg_d;
	logic [2:0] lrst_q, lrst_d;
	logic [2:0] crst_q, crst_d;
	hgc_ld_e ld_q, ld_d;
	logic [15:0] ld_cnt_q, ld_cnt_d;
	logic [7:0] rdata_q, rdata_d;
	logic [NUM_TX*3-1:0] tx_q, tx_d;
	logic det_ok;
	logic regs_rst;
	logic logic_clr;
	assign regs_rst = sys_rst || (crst_q != 3'h0); // R5
	assign logic_clr = regs_rst || (lrst_q != 3'h0); // R6
	hgc_refclk_det #(
		.WIN_CYC(WIN_CYC)
	) u_det (
		.clk_sys(clk_sys),
		.sys_rst(logic_clr),
		.ref_clk_pin(ref_clk_pin),
		.refclk_ok(det_ok)
	);
	function automatic hgc_tx_e tx_policy(input logic [7:0] cfg, input logic lock);
		hgc_tx_e s;
		s = HGC_TX_NORMAL;
		if (!lock) begin
			if (!cfg[`HGC_BIT_OMODE]) begin
				s = HGC_TX_HIZ; // R9
			end else if (cfg[`HGC_BIT_SLEEP] && !cfg[`HGC_BIT_OEN]) begin
				s = HGC_TX_HIZ; // R11
			end else if (!cfg[`HGC_BIT_SLEEP]) begin
				s = HGC_TX_HS0; // R12
			end else begin
				s = HGC_TX_NORMAL; // R10
			end
		end
		return s;
	endfunction : tx_policy
	// Register bank state, strap capture and soft reset pulses
	always_comb begin
		strap_pend_d = 1'b0;
		strap_d = strap_q;
		addr_d = addr_q;
		ovr_d = ovr_q;
		cfg_d = cfg_q;
		lrst_d = (lrst_q != 3'h0) ? lrst_q - 3'h1 : 3'h0;
		crst_d = (crst_q != 3'h0) ? crst_q - 3'h1 : 3'h0;
		if (strap_pend_q) begin
			strap_d = strap_addr;
		end
		if (reg_wr) begin
			case (reg_addr)
				`HGC_OFS_ADDR: begin
					ovr_d = reg_wdata[`HGC_BIT_OVR];
					if (reg_wdata[`HGC_BIT_OVR]) begin
						addr_d = reg_wdata[7:1]; // R2
					end
				end
				`HGC_OFS_RST: begin
					if (reg_wdata[`HGC_BIT_RST1]) begin
						crst_d = RST_LEN; // R5
					end
					if (reg_wdata[`HGC_BIT_RST0] || reg_wdata[`HGC_BIT_RST1]) begin
						lrst_d = RST_LEN; // R5 R6
					end
				end
				`HGC_OFS_CFG: cfg_d = {2'h0, reg_wdata[5:0]};
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			strap_pend_q <= 1'b1;
			strap_q <= 7'h00;
		end else begin
			strap_pend_q <= strap_pend_d;
			strap_q <= strap_d;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lrst_q <= 3'h0;
			crst_q <= 3'h0;
		end else begin
			lrst_q <= lrst_d;
			crst_q <= crst_d;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (regs_rst) begin
			addr_q <= 7'h00;
			ovr_q <= 1'b0;
			cfg_q <= `HGC_CFG_RESET; // R8 R13
		end else begin
			addr_q <= addr_d;
			ovr_q <= ovr_d;
			cfg_q <= cfg_d;
		end
	end
	// ROM reload sequencer
	always_comb begin
		ld_d = ld_q;
		ld_cnt_d = ld_cnt_q;
		case (ld_q)
			HGC_LD_IDLE: begin
				if (reg_wr && reg_addr == `HGC_OFS_RST && reg_wdata[`HGC_BIT_RELOAD]) begin
					ld_d = HGC_LD_BUSY; // R3
					ld_cnt_d = 16'h0000;
				end
			end
			HGC_LD_BUSY: begin
				ld_cnt_d = ld_cnt_q + 16'h0001;
				if (ld_cnt_q == 16'(LOAD_CYC - 1)) begin
					ld_d = HGC_LD_DONE; // R4
				end
			end
			HGC_LD_DONE: begin
				if (reg_wr && reg_addr == `HGC_OFS_RST && reg_wdata[`HGC_BIT_RELOAD]) begin
					ld_d = HGC_LD_BUSY; // R17
					ld_cnt_d = 16'h0000;
				end
			end
			default: ld_d = HGC_LD_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (logic_clr) begin
			ld_q <= HGC_LD_BUSY;
			ld_cnt_q <= 16'h0000;
		end else begin
			ld_q <= ld_d;
			ld_cnt_q <= ld_cnt_d;
		end
	end
	// Read data and output policy
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				`HGC_OFS_ADDR: rdata_d = {bus_address_field, ovr_q}; // R1
				`HGC_OFS_RST: rdata_d = 8'h00; // R17
				`HGC_OFS_CFG: rdata_d = cfg_q;
				`HGC_OFS_REV: rdata_d = {`HGC_REV_VAL, `HGC_MASK_VAL}; // R16
				default: rdata_d = 8'h00;
			endcase
		end
		for (int i = 0; i < NUM_TX; i++) begin
			tx_d[i*3 +: 3] = tx_policy(cfg_q, tx_any_lock[i]);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (logic_clr) begin
			rdata_q <= 8'h00;
			tx_q <= {NUM_TX{HGC_TX_HIZ}};
		end else begin
			rdata_q <= rdata_d;
			tx_q <= tx_d;
		end
	end
	assign bus_address_field = ovr_q ? addr_q : strap_q; // R1 R2
	assign reg_rdata = rdata_q;
	assign logic_rst = lrst_q != 3'h0;
	assign cfg_rst = crst_q != 3'h0;
	assign rom_load_busy = ld_q == HGC_LD_BUSY;
	assign cfg_init_done = ld_q == HGC_LD_DONE; // R4
	assign i2c_master_en = cfg_q[`HGC_BIT_MEN]; // R8
	assign parity_check_en = cfg_q[`HGC_BIT_PAR]; // R13
	assign refclock_ok_flag = cfg_q[`HGC_BIT_REFF] | det_ok; // R14
	assign tx_state = tx_q;
endmodule : hgc_global_regs
`default_nettype wire

// >>> testbench/hgc_global_regs_asserts.sv
// Purpose: Port assertions for the global register bank
// Assumes: One clock domain
// Notes: Accesses inside a soft reset are not judged, except writes of reset bit 1, or of reset bit 0 outside a config reset, to the reset register
`timescale 1ns/10ps
`default_nettype none
module hgc_global_regs_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [6:0] bus_address_field,
	input wire logic logic_rst,
	input wire logic cfg_rst,
	input wire logic rom_load_busy,
	input wire logic cfg_init_done,
	input wire logic i2c_master_en,
	input wire logic parity_check_en,
	input wire logic refclock_ok_flag
);
	wire logic w1 = reg_wr && reg_addr == 8'h01;
	wire logic w2 = reg_wr && reg_addr == 8'h02 && !logic_rst && !cfg_rst;
	wire logic rk = reg_rd && !logic_rst;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_rev; rk && reg_addr == 8'h03 |=> reg_rdata == 8'h90; endproperty
	a_rev: assert property (p_rev) else $error("bad revision");
	property p_rsc; rk && reg_addr == 8'h01 |=> reg_rdata == 8'h00; endproperty
	a_rsc: assert property (p_rsc) else $error("reset bits read set");
	property p_ovr; reg_wr && !logic_rst && reg_addr == 8'h00 && reg_wdata[0]
		|=> bus_address_field == $past(reg_wdata[7:1]); endproperty
	a_ovr: assert property (p_ovr) else $error("address not taken");
	property p_full; w1 && reg_wdata[1] |=> cfg_rst && logic_rst; endproperty
	a_full: assert property (p_full) else $error("no full reset");
	property p_keep; w1 && reg_wdata[1:0] == 2'b01 && !cfg_rst |=> logic_rst && !cfg_rst; endproperty
	a_keep: assert property (p_keep) else $error("bad logic reset");
	property p_load; w1 && reg_wdata[2] && !rom_load_busy && !logic_rst |=> rom_load_busy; endproperty
	a_load: assert property (p_load) else $error("no reload");
	property p_done; $fell(rom_load_busy) |-> cfg_init_done; endproperty
	a_done: assert property (p_done) else $error("done flag missing");
	property p_en; w2 |=> i2c_master_en == $past(reg_wdata[5]) &&
		parity_check_en == $past(reg_wdata[1]) && refclock_ok_flag >= $past(reg_wdata[0]); endproperty
	a_en: assert property (p_en) else $error("config outputs wrong");
endmodule : hgc_global_regs_asserts
`default_nettype wire

// >>> testbench/hgc_host_model.sv
// Purpose: Host issuing byte register accesses
// Assumes: Strobes change at the falling edge
// Notes: Idle address and data carry inverted junk
`timescale 1ns/10ps
`default_nettype none
module hgc_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hff;
		reg_wdata = 8'h00;
	end
	task automatic acc(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk_sys);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : acc
endmodule : hgc_host_model
`default_nettype wire

// >>> testbench/hgc_global_regs_tb.sv
// Purpose: Self-checking bench for the global register bank
// Assumes: Reference pin carries 20 MHz divided by 16 when running
// Notes: Detector window shortened to 100 cycles
`include "hgc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module hgc_global_regs_tb;
	import hgc_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic ref_clk_pin = 1'b0;
	logic ref_run = 1'b0;
	logic [1:0] tx_any_lock = 2'b00;
	logic [6:0] strap_addr, bus_address_field;
	logic reg_wr, reg_rd, logic_rst, cfg_rst, rom_load_busy, cfg_init_done;
	logic i2c_master_en, parity_check_en, refclock_ok_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q, w;
	logic [5:0] tx_state;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	integer seed = 32'h5e80c48d;
	int m_cfg = 8'h1e;
	int m_addr;
	logic [7:0] dir_cfg [4] = '{8'h00, 8'h10, 8'h14, 8'h1c};
	always #20 clk_sys = ~clk_sys;
	always #400 ref_clk_pin = ref_run & ~ref_clk_pin;
	hgc_global_regs #(.NUM_TX(2), .LOAD_CYC(16), .WIN_CYC(100)) DUT (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .strap_addr(strap_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ref_clk_pin(ref_clk_pin), .tx_any_lock(tx_any_lock), .bus_address_field(bus_address_field),
		.logic_rst(logic_rst), .cfg_rst(cfg_rst), .rom_load_busy(rom_load_busy),
		.cfg_init_done(cfg_init_done), .i2c_master_en(i2c_master_en),
		.parity_check_en(parity_check_en), .refclock_ok_flag(refclock_ok_flag), .tx_state(tx_state));
	hgc_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input int e);
		host.acc(1'b0, a, 8'h00, q);
		chk(q, 8'(e));
	endtask : rd
	function automatic logic [2:0] exp_tx(input int c, input logic lk);
		if (lk || (c[4] && c[2] && c[3])) return HGC_TX_NORMAL;
		if (!c[4] || c[2]) return HGC_TX_HIZ;
		return HGC_TX_HS0;
	endfunction : exp_tx
	task automatic wait_load;
		@(negedge clk_sys);
		for (int n = 0; n < 200 && cfg_init_done !== 1'b1; n++) @(negedge clk_sys);
		chk({7'h0, cfg_init_done}, 8'h01);
	endtask : wait_load
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		strap_addr = 7'($random(seed));
		m_addr = {strap_addr, 1'b0};
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		wait_load();
		rd(8'h00, m_addr);
		rd(8'h02, m_cfg);
		host.acc(1'b1, 8'h03, 8'h5a, q);
		rd(8'h03, {`HGC_REV_VAL, `HGC_MASK_VAL});
		rd(8'h40, 0);
		host.acc(1'b1, 8'h00, 8'h34, q);
		rd(8'h00, m_addr);
		host.acc(1'b1, 8'h00, 8'h35, q);
		rd(8'h00, 8'h35);
		chk({1'b0, bus_address_field}, 8'h1a);
		for (int i = 0; i < 20; i++) begin
			w = (i < 4) ? dir_cfg[i] : 8'($random(seed));
			m_cfg = w & 8'h3f;
			tx_any_lock = (i < 4) ? 2'b10 : 2'($random(seed));
			host.acc(1'b1, 8'h02, w, q);
			repeat (3) @(negedge clk_sys);
			rd(8'h02, m_cfg);
			chk({6'h0, i2c_master_en, parity_check_en}, 8'({m_cfg[5], m_cfg[1]}));
			chk({7'h0, refclock_ok_flag}, 8'(m_cfg[0]));
			chk({5'h0, tx_state[2:0]}, {5'h0, exp_tx(m_cfg, tx_any_lock[0])});
			chk({5'h0, tx_state[5:3]}, {5'h0, exp_tx(m_cfg, tx_any_lock[1])});
		end
		m_cfg = 8'h1e;
		host.acc(1'b1, 8'h02, 8'h1e, q);
		ref_run = 1'b1;
		repeat (300) @(negedge clk_sys);
		chk({7'h0, refclock_ok_flag}, 8'h01);
		ref_run = 1'b0;
		repeat (300) @(negedge clk_sys);
		chk({7'h0, refclock_ok_flag}, 8'h00);
		m_cfg = 8'h21;
		host.acc(1'b1, 8'h02, 8'h21, q);
		host.acc(1'b1, 8'h01, 8'h01, q);
		chk({6'h0, cfg_rst, logic_rst}, 8'h01);
		wait_load();
		rd(8'h02, m_cfg);
		rd(8'h00, 8'h35);
		rd(8'h01, 0);
		host.acc(1'b1, 8'h01, 8'h02, q);
		chk({6'h0, cfg_rst, logic_rst}, 8'h03);
		wait_load();
		rd(8'h00, m_addr);
		rd(8'h02, 8'h1e);
		for (int i = 0; i < 2; i++) begin
			host.acc(1'b1, 8'h01, 8'h04, q);
			chk({7'h0, rom_load_busy}, 8'h01);
			wait_load();
		end
		rd(8'h01, 0);
		finish_test();
	end
endmodule : hgc_global_regs_tb
bind hgc_global_regs hgc_global_regs_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .bus_address_field(bus_address_field), .logic_rst(logic_rst),
	.cfg_rst(cfg_rst), .rom_load_busy(rom_load_busy), .cfg_init_done(cfg_init_done),
	.i2c_master_en(i2c_master_en), .parity_check_en(parity_check_en),
	.refclock_ok_flag(refclock_ok_flag));
`default_nettype wire
